// ===== pdc_pkg.sv
// Shared constants and types for the programmable divide counter pair.
// Assumes one system clock and one synchronous active-low reset.
package pdc_pkg;

   // ------------------------------------------------------------
   // Counter geometry
   // ------------------------------------------------------------
   localparam int          DIGIT_W   = 4;
   localparam logic [3:0]  HEX_TOP   = 4'hf;
   localparam logic [3:0]  DEC_TOP   = 4'h9;
   localparam logic [3:0]  DIGIT_MIN = 4'h0;

   // ------------------------------------------------------------
   // Select encoding {select_line_a, select_line_b}
   // ------------------------------------------------------------
   localparam logic [1:0]  SEL_PRESET = 2'h0;
   localparam logic [1:0]  SEL_UP     = 2'h1;
   localparam logic [1:0]  SEL_DOWN   = 2'h2;
   localparam logic [1:0]  SEL_HOLD   = 2'h3;

   // ------------------------------------------------------------
   // Divider methods and controller states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PDC_M_FEEDBACK = 2'b00,
      PDC_M_DECODE   = 2'b01,
      PDC_M_GOBBLE   = 2'b10
   } pdc_method_e;

   typedef enum logic [1:0] {
      PDC_ST_IDLE = 2'b00,
      PDC_ST_RUN  = 2'b01
   } pdc_state_e;

   // ------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ------------------------------------------------------------
   localparam int          ADDR_W        = 4;
   localparam logic [3:0]  CTRL_OFF      = 4'h0;
   localparam logic [3:0]  DIVISOR_OFF   = 4'h4;
   localparam logic [3:0]  STATUS_OFF    = 4'h8;
   localparam logic [3:0]  PULSES_OFF    = 4'hc;
   localparam int          CTRL_RUN_BIT  = 0;
   localparam int          CTRL_METH_LSB = 1;
   localparam int          STAT_RUN_BIT  = 0;
   localparam int          STAT_BAD_BIT  = 1;
   localparam int          STAT_CNT_LSB  = 8;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   localparam logic [31:0] DIVISOR_RESET = 32'h0000_0002;

endpackage

// ===== pdc_link_if.sv
// Link between the universal counter and its divider controller.
// Assumes the bench supplies aclk and aresetn to both ends.
`timescale 1ns/1ps
interface pdc_link_if #(
   parameter int STAGES = 1
) (
   input wire logic aclk,
   input wire logic aresetn
);
   logic                          select_line_a;
   logic                          select_line_b;
   logic                          carry_in_n;
   logic [4*STAGES-1:0]           preset_data;
   logic [4*STAGES-1:0]           count_q;
   logic                          carry_out_n;

   modport dev (
      input  aclk, aresetn, select_line_a, select_line_b, carry_in_n, preset_data,
      output count_q, carry_out_n
   );
   modport ctl (
      input  aclk, aresetn, count_q, carry_out_n,
      output select_line_a, select_line_b, carry_in_n, preset_data
   );
endinterface

// ===== pdc_counter_dev.sv
// Four-bit universal counter, hexadecimal or decade, one or two stages.
// Assumes the controller end drives selects, carry-in and preset data.
//
// Operation
// - Binary variant counts zero through fifteen
// - Decimal variant counts zero through nine
// - Two selects pick preset, up, down, hold
// - Both selects low loads preset data
// - State changes only on rising clock edge
// - High carry-in stops up and down counting
// - Down mode carry-out low at zero
// - Up mode carry-out low at top
// - Carry-out is carry-in ORed with decode, forced low in preset
// - Cascade stages chain carry, share clock
// - Feedback divider reloads N, divides N+1
// - Carry-out steers select a; avoid lock-up; the controller instead steers select a from a registered count_q decode
// - Single stage moduli 1-16 or 1-10
// - Two stages reach 256 or 100
// - Early decode gives modulus N
// - Gobble flop pulls select a low
// - Gobble divides by N, 255 max
// - Divisor N coded to match variant
`timescale 1ns/1ps
module pdc_counter_dev #(
   parameter bit DECIMAL = 1'b0,
   parameter int STAGES  = 1
) (
   pdc_link_if.dev                    link,
   output logic [4*STAGES-1:0]        count_value,
   output logic                       terminal_hit
);

   localparam int         W   = 4 * STAGES;
   localparam logic [3:0] TOP = DECIMAL ? pdc_pkg::DEC_TOP : pdc_pkg::HEX_TOP;

   // ------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------
   if (STAGES < 1 || STAGES > 2) begin : g_bad_stages
      $error("pdc_counter_dev: STAGES must be 1 or 2");
   end

   // ------------------------------------------------------------
   // Digit helpers
   // ------------------------------------------------------------
   function automatic logic [3:0] step_digit(input logic [3:0] d, input logic up);
      logic [3:0] r;
      r = d;
      if (up) begin
         if (d >= TOP) begin
            r = pdc_pkg::DIGIT_MIN;
         end else begin
            r = d + 4'h1;
         end
      end else begin
         if (d == pdc_pkg::DIGIT_MIN) begin
            r = TOP;
         end else begin
            r = d - 4'h1;
         end
      end
      return r;
   endfunction

   function automatic logic at_terminal(input logic [3:0] d, input logic [1:0] sel);
      logic t;
      t = 1'b0;
      case (sel)
         pdc_pkg::SEL_UP:     t = (d == TOP);
         pdc_pkg::SEL_DOWN:   t = (d == pdc_pkg::DIGIT_MIN);
         pdc_pkg::SEL_PRESET: t = 1'b1;
         default:             t = (d == pdc_pkg::DIGIT_MIN);
      endcase
      return t;
   endfunction

   // ------------------------------------------------------------
   // Stage chain
   // ------------------------------------------------------------
   logic [1:0]      sel;
   logic [STAGES:0] carry_n;
   logic [W-1:0]    q_all;

   assign sel        = {link.select_line_a, link.select_line_b};
   assign carry_n[0] = link.carry_in_n;

   for (genvar s = 0; s < STAGES; s++) begin : g_stage
      logic [3:0] digit_r;
      logic [3:0] digit_nxt;

      always_comb begin
         digit_nxt = digit_r;
         case (sel)
            pdc_pkg::SEL_PRESET: begin
               digit_nxt = link.preset_data[4*s +: 4];
            end
            pdc_pkg::SEL_UP: begin
               if (!carry_n[s]) begin
                  digit_nxt = step_digit(digit_r, 1'b1);
               end
            end
            pdc_pkg::SEL_DOWN: begin
               if (!carry_n[s]) begin
                  digit_nxt = step_digit(digit_r, 1'b0);
               end
            end
            default: begin
               digit_nxt = digit_r;
            end
         endcase
      end

      // No reset on the count itself; first preset defines it
      always_ff @(posedge link.aclk) begin
         digit_r <= digit_nxt;
      end

      // Preset forces carry-out low, which AST_CARRY_PRESET checks
      assign carry_n[s+1] = carry_n[s] | ~at_terminal(digit_r, sel);
      assign q_all[4*s +: 4] = digit_r;
   end

   assign link.count_q     = q_all;
   assign link.carry_out_n = (sel == pdc_pkg::SEL_PRESET) ? 1'b0 : carry_n[STAGES];

   // ------------------------------------------------------------
   // User-side copies
   // ------------------------------------------------------------
   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         count_value <= '0;
      end else begin
         count_value <= q_all;
      end
   end

   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         terminal_hit <= 1'b0;
      end else begin
         terminal_hit <= ~link.carry_out_n;
      end
   end

endmodule

// ===== pdc_divider_ctl.sv
// Divider controller driving the universal counter; AXI4-Lite registers.
// Assumes the counter end shares aclk and answers on the link combinationally.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module pdc_divider_ctl #(
   parameter bit DECIMAL = 1'b0,
   parameter int STAGES  = 1
) (
   pdc_link_if.ctl                    link,
   input  wire logic [3:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [3:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic                       divided_out
);

   localparam int         W   = 4 * STAGES;
   localparam logic [3:0] TOP = DECIMAL ? pdc_pkg::DEC_TOP : pdc_pkg::HEX_TOP;

   if (STAGES < 1 || STAGES > 2) begin : g_bad_stages
      $error("pdc_divider_ctl: STAGES must be 1 or 2");
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [31:0]             ctrl_r;
   logic [31:0]             divisor_r;
   logic [31:0]             pulses_r;
   pdc_pkg::pdc_state_e     state_r;
   logic                    sel_a_r;
   logic                    sel_b_r;
   logic                    cin_n_r;
   logic [W-1:0]            preset_r;
   logic                    divided_r;

   wire  [W-1:0]            n_val  = divisor_r[W-1:0];
   wire  [1:0]              method = ctrl_r[pdc_pkg::CTRL_METH_LSB +: 2];
   wire  [1:0]              sel_now = {sel_a_r, sel_b_r};
   wire                     loading = (sel_now == pdc_pkg::SEL_PRESET);
   wire                     down    = (sel_now == pdc_pkg::SEL_DOWN);

   // ------------------------------------------------------------
   // Divisor range check
   // ------------------------------------------------------------
   function automatic logic divisor_ok(input logic [W-1:0] n, input logic [1:0] m);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < STAGES; i++) begin
         if (n[4*i +: 4] > TOP) begin
            ok = 1'b0;
         end
      end
      if (m == pdc_pkg::PDC_M_DECODE || m == pdc_pkg::PDC_M_GOBBLE) begin
         if (n < W'(2)) begin
            ok = 1'b0;
         end
         if (STAGES == 1 && n == W'(TOP) && m == pdc_pkg::PDC_M_DECODE) begin
            ok = ok;
         end
      end else if (m != pdc_pkg::PDC_M_FEEDBACK) begin
         ok = 1'b0;
      end
      return ok;
   endfunction

   wire bad_div = ~divisor_ok(n_val, method);

   // ------------------------------------------------------------
   // Run state
   // ------------------------------------------------------------
   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         state_r <= pdc_pkg::PDC_ST_IDLE;
      end else begin
         case (state_r)
            pdc_pkg::PDC_ST_IDLE: begin
               if (ctrl_r[pdc_pkg::CTRL_RUN_BIT] && !bad_div) begin
                  state_r <= pdc_pkg::PDC_ST_RUN;
               end
            end
            default: begin
               if (!ctrl_r[pdc_pkg::CTRL_RUN_BIT] || bad_div) begin
                  state_r <= pdc_pkg::PDC_ST_IDLE;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Counter steering: selects registered one edge ahead
   // ------------------------------------------------------------
   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         sel_a_r <= 1'b0;
      end else if (state_r != pdc_pkg::PDC_ST_RUN) begin
         sel_a_r <= 1'b0;
      end else begin
         case (method)
            pdc_pkg::PDC_M_FEEDBACK: begin
               sel_a_r <= ~((down && link.count_q == W'(1)) ||
                            (loading && n_val == '0));
            end
            pdc_pkg::PDC_M_DECODE: begin
               sel_a_r <= ~(down && link.count_q == W'(2));
            end
            default: begin
               sel_a_r <= ~(down && link.count_q == W'(2));
            end
         endcase
      end
   end

   // Select b and carry-in sit at their clock-low levels
   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         sel_b_r <= 1'b0;
         cin_n_r <= 1'b0;
      end else begin
         sel_b_r <= 1'b0;
         cin_n_r <= 1'b0;
      end
   end

   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         preset_r <= '0;
      end else begin
         preset_r <= n_val;
      end
   end

   assign link.select_line_a = sel_a_r;
   assign link.select_line_b = sel_b_r;
   assign link.carry_in_n    = cin_n_r;
   assign link.preset_data   = preset_r;

   // ------------------------------------------------------------
   // Divided output and pulse tally
   // ------------------------------------------------------------
   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         divided_r <= 1'b0;
      end else begin
         divided_r <= loading && state_r == pdc_pkg::PDC_ST_RUN;
      end
   end

   assign divided_out = divided_r;

   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         pulses_r <= '0;
      end else if (loading && state_r == pdc_pkg::PDC_ST_RUN) begin
         pulses_r <= pulses_r + 32'h1;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite write path
   // ------------------------------------------------------------
   logic       aw_have_r;
   logic       w_have_r;
   logic [3:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   wire do_write = aw_have_r && w_have_r && !s_axi_bvalid;

   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end else if (do_write) begin
         aw_have_r <= 1'b0;
      end
   end

   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         w_have_r <= 1'b0;
         w_data_r <= '0;
         w_strb_r <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end else if (do_write) begin
         w_have_r <= 1'b0;
      end
   end

   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
      end
   end

   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         ctrl_r    <= pdc_pkg::CTRL_RESET;
         divisor_r <= pdc_pkg::DIVISOR_RESET;
      end else if (do_write) begin
         if (aw_addr_r == pdc_pkg::CTRL_OFF) begin
            ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r);
         end else if (aw_addr_r == pdc_pkg::DIVISOR_OFF) begin
            divisor_r <= merge(divisor_r, w_data_r, w_strb_r);
         end
      end
   end

   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= pdc_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         if (aw_addr_r == pdc_pkg::CTRL_OFF || aw_addr_r == pdc_pkg::DIVISOR_OFF) begin
            s_axi_bresp <= pdc_pkg::RESP_OKAY;
         end else begin
            s_axi_bresp <= pdc_pkg::RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read path
   // ------------------------------------------------------------
   logic [31:0] status_w;

   always_comb begin
      status_w = '0;
      status_w[pdc_pkg::STAT_RUN_BIT] = (state_r == pdc_pkg::PDC_ST_RUN);
      status_w[pdc_pkg::STAT_BAD_BIT] = bad_div;
      status_w[pdc_pkg::STAT_CNT_LSB +: W] = link.count_q;
   end

   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      end
   end

   always_ff @(posedge link.aclk) begin
      if (!link.aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= pdc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= pdc_pkg::RESP_OKAY;
         if (s_axi_araddr == pdc_pkg::CTRL_OFF) begin
            s_axi_rdata <= ctrl_r;
         end else if (s_axi_araddr == pdc_pkg::DIVISOR_OFF) begin
            s_axi_rdata <= divisor_r;
         end else if (s_axi_araddr == pdc_pkg::STATUS_OFF) begin
            s_axi_rdata <= status_w;
         end else if (s_axi_araddr == pdc_pkg::PULSES_OFF) begin
            s_axi_rdata <= pulses_r;
         end else begin
            s_axi_rdata <= '0;
            s_axi_rresp <= pdc_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ===== pdc_link_assertions.sv
// Concurrent checks on the link between counter and divider controller.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module pdc_link_assertions #(
   parameter bit DECIMAL = 1'b0,
   parameter int STAGES  = 1
) (
   input wire logic                aclk,
   input wire logic                aresetn,
   input wire logic                select_line_a,
   input wire logic                select_line_b,
   input wire logic                carry_in_n,
   input wire logic [4*STAGES-1:0] preset_data,
   input wire logic [4*STAGES-1:0] count_q,
   input wire logic                carry_out_n
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   localparam logic [3:0] TOP = DECIMAL ? pdc_pkg::DEC_TOP : pdc_pkg::HEX_TOP;
   logic [1:0] sel;
   logic       dn;
   assign sel = {select_line_a, select_line_b};
   assign dn  = (sel == pdc_pkg::SEL_DOWN) && !carry_in_n;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   AST_PRESET_LOAD: assert property (
      sel == pdc_pkg::SEL_PRESET |=> count_q == $past(preset_data))
      else $error("preset data not loaded");
   AST_DOWN_STEP: assert property (
      dn && count_q != '0 |=> count_q == $past(count_q) - 1'b1)
      else $error("down count did not step by one");
   AST_CARRY_DOWN: assert property (
      dn |-> carry_out_n == (count_q != '0))
      else $error("carry out wrong in down mode");
   AST_CARRY_PRESET: assert property (
      sel == pdc_pkg::SEL_PRESET |-> !carry_out_n)
      else $error("carry out high in preset mode");
   AST_NO_UNDERFLOW: assert property (
      sel == pdc_pkg::SEL_DOWN |-> count_q != '0)
      else $error("down mode held at zero count");
   AST_RANGE: assert property (
      sel == pdc_pkg::SEL_DOWN |-> count_q[3:0] <= TOP)
      else $error("count digit above top");
   AST_FIXED_LINES: assert property (
      !select_line_b && !carry_in_n)
      else $error("select b or carry in not low");
   AST_RESET_PRESET: assert property (
      disable iff (1'b0) !aresetn |=> sel == pdc_pkg::SEL_PRESET && preset_data == '0)
      else $error("reset did not force preset");

   // ------------------------------------------------------------
   // Cover
   // ------------------------------------------------------------
   COV_LOAD: cover property (sel == pdc_pkg::SEL_PRESET ##1 sel == pdc_pkg::SEL_DOWN);
   COV_ZERO: cover property (count_q == '0 && sel == pdc_pkg::SEL_PRESET);
   COV_LAST: cover property (dn && count_q == 1);
endmodule

// ===== programmable_divide_counter_tb_top.sv
// Self-checking bench: counter and divider controller joined by the link.
// Assumes a hexadecimal pair on AXI4-Lite and a bench-driven two-digit decade counter.
`timescale 1ns/1ps
module programmable_divide_counter_tb_top;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        aclk;
   logic        aresetn;
   logic [3:0]  s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [3:0]  s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   logic        divided_out;
   logic [3:0]  count_value;
   logic        terminal_hit;
   logic [31:0] v;
   logic [31:0] u;
   int          p;
   int          err_total = 0;
   int          checks_done = 0;
   int          fb_n[4] = '{0, 1, 15, 5};
   int          dc_n[3] = '{2, 3, 15};

   pdc_link_if i_pdc_link_if (.aclk, .aresetn);
   pdc_counter_dev i_pdc_counter_dev (
      .link(i_pdc_link_if), .count_value, .terminal_hit);
   pdc_link_if #(.STAGES(2)) i_pdc_link_if_dec (.aclk, .aresetn);
   pdc_counter_dev #(.DECIMAL(1'b1), .STAGES(2)) i_pdc_counter_dev_dec (
      .link(i_pdc_link_if_dec), .count_value(), .terminal_hit());
   pdc_divider_ctl i_pdc_divider_ctl (
      .link(i_pdc_link_if), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .divided_out);
   pdc_link_assertions i_pdc_link_assertions (
      .aclk, .aresetn,
      .select_line_a(i_pdc_link_if.select_line_a),
      .select_line_b(i_pdc_link_if.select_line_b),
      .carry_in_n(i_pdc_link_if.carry_in_n),
      .preset_data(i_pdc_link_if.preset_data),
      .count_q(i_pdc_link_if.count_q),
      .carry_out_n(i_pdc_link_if.carry_out_n));

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      chk(32'(s_axi_bresp), 32'(er));
   endtask

   task automatic rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      chk(32'(s_axi_rresp), 32'(er));
   endtask

   task automatic pulse_wait();
      do @(posedge aclk); while (divided_out !== 1'b1);
   endtask

   // Stop, program divisor and method, restart
   task automatic cfg(input logic [1:0] m, input int n);
      wr(pdc_pkg::CTRL_OFF, 32'h0, pdc_pkg::RESP_OKAY);
      wr(pdc_pkg::DIVISOR_OFF, 32'(n), pdc_pkg::RESP_OKAY);
      wr(pdc_pkg::CTRL_OFF, {29'h0, m, 1'b1}, pdc_pkg::RESP_OKAY);
   endtask

   // Cycles between two output pulses, after one settling period
   task automatic period();
      pulse_wait();
      pulse_wait();
      p = 0;
      do begin
         @(posedge aclk);
         p++;
      end while (divided_out !== 1'b1 && p < 64);
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      s_axi_awaddr = 4'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b1;
      s_axi_araddr = 4'h0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b1;
      aresetn = 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(32'(i_pdc_link_if.count_q), 32'h2);
      rd(pdc_pkg::CTRL_OFF, pdc_pkg::RESP_OKAY, v);
      chk(v, pdc_pkg::CTRL_RESET);
      rd(pdc_pkg::DIVISOR_OFF, pdc_pkg::RESP_OKAY, v);
      chk(v, pdc_pkg::DIVISOR_RESET);
      rd(4'h2, pdc_pkg::RESP_SLVERR, v);
      chk(v, 32'h0);
      wr(pdc_pkg::PULSES_OFF, 32'h1, pdc_pkg::RESP_SLVERR);
      foreach (fb_n[i]) begin
         cfg(2'h0, fb_n[i]);
         period();
         chk(32'(p), 32'(fb_n[i] + 1));
      end
      // One full down-count walk at divisor five
      pulse_wait();
      for (int k = 0; k <= 5; k++) begin
         chk(32'(i_pdc_link_if.count_q), 32'(5 - k));
         chk(32'(i_pdc_link_if.carry_out_n), 32'(k != 5));
         chk(32'(count_value), 32'((6 - k) % 6));
         chk(32'(terminal_hit), 32'(k == 0));
         @(posedge aclk);
      end
      foreach (dc_n[i]) begin
         cfg(2'h1, dc_n[i]);
         period();
         chk(32'(p), 32'(dc_n[i]));
         cfg(2'h2, dc_n[i]);
         period();
         chk(32'(p), 32'(dc_n[i]));
      end
      rd(pdc_pkg::STATUS_OFF, pdc_pkg::RESP_OKAY, v);
      chk(v & 32'h3, 32'h1);
      wr(pdc_pkg::CTRL_OFF, 32'h0, pdc_pkg::RESP_OKAY);
      rd(pdc_pkg::PULSES_OFF, pdc_pkg::RESP_OKAY, v);
      repeat (20) begin
         @(posedge aclk);
         chk(32'(divided_out), 32'h0);
      end
      rd(pdc_pkg::PULSES_OFF, pdc_pkg::RESP_OKAY, u);
      chk(u, v);
      cfg(2'h1, 1);
      rd(pdc_pkg::STATUS_OFF, pdc_pkg::RESP_OKAY, v);
      chk(v & 32'h3, 32'h2);
      // Two decade stages: load 98, count up through 99 to 00, then hold
      i_pdc_link_if_dec.select_line_a <= 1'b0;
      i_pdc_link_if_dec.select_line_b <= 1'b0;
      i_pdc_link_if_dec.carry_in_n <= 1'b0;
      i_pdc_link_if_dec.preset_data <= 8'h98;
      @(posedge aclk);
      i_pdc_link_if_dec.select_line_b <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(32'(i_pdc_link_if_dec.count_q), 32'h99);
      chk(32'(i_pdc_link_if_dec.carry_out_n), 32'h0);
      i_pdc_link_if_dec.carry_in_n <= 1'b1;
      @(posedge aclk);
      chk(32'(i_pdc_link_if_dec.count_q), 32'h0);
      @(posedge aclk);
      chk(32'(i_pdc_link_if_dec.count_q), 32'h0);
      chk(32'(i_pdc_link_if_dec.carry_out_n), 32'h1);
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      end_of_test();
   end
endmodule
